// ==== logic/ssl_map.svh ====
`ifndef SSL_MAP_SVH
`define SSL_MAP_SVH

// Register indices on the plain register port
`define SSL_IDX_ZERO_WIN     4'h0
`define SSL_IDX_FULL_SPEED   4'h1
`define SSL_IDX_TORQUE_FS    4'h2
`define SSL_IDX_ENC_SETTING  4'h3
`define SSL_IDX_INT_TLIM     4'h4
`define SSL_IDX_SPEED_OFS    4'h5
`define SSL_IDX_CONTROL      4'h6
`define SSL_IDX_STATUS       4'h7
`define SSL_IDX_MASK         4'h8

// Reset values
`define SSL_RST_ZERO_WIN     16'h0032
`define SSL_RST_FULL_SPEED   16'h0000
`define SSL_RST_TORQUE_FS    16'h0064
`define SSL_RST_ENC_SETTING  16'h0FA0
`define SSL_RST_INT_TLIM     16'h0064
`define SSL_RST_SPEED_OFS    16'h0000
`define SSL_RST_CONTROL      16'h0000
`define SSL_RST_MASK         16'h0000

// Setting ranges
`define SSL_MAX_ZERO_WIN     16'h2710
`define SSL_MAX_FULL_SPEED   16'hC350
`define SSL_MAX_TORQUE_FS    16'h03E8
`define SSL_MAX_INT_TLIM     16'h0064
`define SSL_MAX_OFS_MV       16'h03E7

// Analog full scales in millivolts, percent base
`define SSL_SPEED_FS_MV      16'h2710
`define SSL_TORQUE_FS_MV     16'h1F40
`define SSL_TLIM_FS_MV       16'h2710
`define SSL_MONITOR_FS_MV    16'h1F40
`define SSL_PERCENT_BASE     16'h0064

// Encoder counts per motor revolution
`define SSL_ENC_RESOLUTION   16'h2710

// Field positions
`define SSL_CTRL_RATIO_BIT   0
`define SSL_CTRL_LIMIT_BIT   1
`define SSL_ST_ZERO_BIT      0
`define SSL_ST_TLIM_BIT      1
`define SSL_ST_OFS_BIT       2

`endif

// ==== logic/ssl_pkg.sv ====
package ssl_pkg;

    timeunit 1ns;
    timeprecision 1ns;

    // Analog inputs as signed millivolt samples
    typedef struct packed {
        logic signed [15:0] speedCmdMv;
        logic signed [15:0] speedLimitMv;
        logic signed [15:0] torqueCmdMv;
        logic signed [15:0] torqueLimitMv;
    } ssl_analog_s;

    // Scaled references towards the control loops
    typedef struct packed {
        logic signed [16:0] speedRefRpm;
        logic signed [16:0] speedLimitRpm;
        logic signed [15:0] torqueRefPct;
        logic [15:0] torqueLimitPct;
        logic signed [15:0] monitorMv;
    } ssl_drive_s;

    // Encoder output pulse mode
    typedef enum logic [1:0] {
        SSL_ENC_PULSES = 2'b01,
        SSL_ENC_RATIO = 2'b10
    } ssl_encmode_e;

endpackage

// ==== logic/ssl_servo_scaling.sv ====
`include "ssl_map.svh"

module ssl_servo_scaling
    import ssl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // Analog samples and discrete signals
    input wire ssl_analog_s analogIn,
    input wire logic torqueLimitSelect,
    input wire logic autoOffsetStart,
    // Motor feedback
    input wire logic signed [16:0] motorSpeedRpm,
    input wire logic [15:0] ratedSpeedRpm,
    input wire logic encStep,
    input wire logic encReverse,
    // Results
    output ssl_drive_s driveOut,
    output logic zeroSpeedFlag,
    output logic encOutA,
    output logic encOutB,
    output logic irq
);

    timeunit 1ns;
    timeprecision 1ns;

    // Settings and control
    logic [15:0] zeroSpeedWindow;
    logic [15:0] analogFullScaleSpeed;
    logic [15:0] torqueCommandFullScale;
    logic [15:0] encoderOutputPulseSetting;
    logic [15:0] internalTorqueLimit;
    logic signed [15:0] speedInputOffset;
    logic [15:0] control;
    logic [2:0] status;
    logic [2:0] mask;
    ssl_encmode_e encMode;

    // Encoder divider state
    logic [16:0] encAcc;
    logic [1:0] quadPhase;

    // Combinational results
    ssl_drive_s next_drive;
    logic next_zero;
    logic [2:0] events;
    logic quadStep;
    logic [16:0] next_encAcc;
    logic [15:0] fullSpeed;
    logic [15:0] analogLimitPct;
    logic [15:0] activeLimit;
    logic signed [16:0] offsetCmd;
    logic signed [16:0] offsetLim;
    logic signed [31:0] torqueRaw;
    logic signed [16:0] speedRef;
    logic signed [16:0] speedLim;
    logic signed [15:0] torqueRef;
    logic signed [15:0] monitorOut;
    logic regWrite;
    logic statusRead;

    // Signed linear scale v * num / den, symmetric about zero
    function automatic logic signed [31:0] scale(
        input logic signed [16:0] v,
        input logic [15:0] num,
        input logic [15:0] den
    );
        logic signed [39:0] prod;
        logic signed [39:0] quot;
        prod = 40'(v) * $signed({24'h00_0000, num});
        if (den == 16'h0000) begin
            quot = 40'sh00_0000_0000;
        end else begin
            quot = prod / $signed({24'h00_0000, den});
        end
        return quot[31:0];
    endfunction

    // Clamp an unsigned write to its setting range
    function automatic logic [15:0] clampU(
        input logic [15:0] v,
        input logic [15:0] hi
    );
        return (v > hi) ? hi : v;
    endfunction

    // Clamp a signed millivolt value to plus or minus the offset limit
    function automatic logic signed [15:0] clampOfs(
        input logic signed [16:0] v
    );
        logic signed [16:0] hi;
        hi = $signed({1'b0, `SSL_MAX_OFS_MV});
        if (v > hi) begin
            return hi[15:0];
        end else if (v < -hi) begin
            return 16'(-hi);
        end
        return v[15:0];
    endfunction

    // Saturate a wide signed value into a narrower signed field
    function automatic logic signed [16:0] sat17(
        input logic signed [31:0] v
    );
        if (v > 32'sh0000_FFFF) begin
            return 17'sh0_FFFF;
        end else if (v < -32'sh0001_0000) begin
            return -17'sh1_0000;
        end
        return v[16:0];
    endfunction

    assign regWrite = regWr && !regRd;
    assign statusRead = regRd && (regAddr == `SSL_IDX_STATUS);
    assign encMode = control[`SSL_CTRL_RATIO_BIT] ? SSL_ENC_RATIO
                                                  : SSL_ENC_PULSES;

    // Speed paths: offset, then linear scale to the full scale speed
    always_comb begin
        fullSpeed = (analogFullScaleSpeed == 16'h0000) ? ratedSpeedRpm
                                                        : analogFullScaleSpeed;
        offsetCmd = 17'(analogIn.speedCmdMv) + 17'(speedInputOffset);
        offsetLim = 17'(analogIn.speedLimitMv) + 17'(speedInputOffset);
        speedRef = sat17(scale(offsetCmd, fullSpeed,
                               `SSL_SPEED_FS_MV));
        if (control[`SSL_CTRL_LIMIT_BIT]) begin
            speedLim = sat17(scale(offsetLim, fullSpeed,
                                   `SSL_SPEED_FS_MV));
        end else begin
            speedLim = $signed({1'b0, fullSpeed});
        end
    end

    // Torque path: command scaling, limit choice, clamp, monitor
    always_comb begin
        torqueRaw = scale(17'(analogIn.torqueCmdMv), torqueCommandFullScale,
                          `SSL_TORQUE_FS_MV);
        if (analogIn.torqueLimitMv <= 16'sh0000) begin
            analogLimitPct = 16'h0000;
        end else begin
            analogLimitPct = 16'(scale(17'(analogIn.torqueLimitMv),
                                       `SSL_PERCENT_BASE,
                                       `SSL_TLIM_FS_MV));
        end
        // Smaller of analog and internal only while selected
        if (torqueLimitSelect && (analogLimitPct < internalTorqueLimit)) begin
            activeLimit = analogLimitPct;
        end else begin
            activeLimit = internalTorqueLimit;
        end
        // Zero limit forces zero torque in either direction
        if (torqueRaw > $signed({16'h0000, activeLimit})) begin
            torqueRef = $signed(activeLimit);
        end else if (torqueRaw < -$signed({16'h0000, activeLimit})) begin
            torqueRef = 16'(-$signed({16'h0000, activeLimit}));
        end else begin
            torqueRef = torqueRaw[15:0];
        end
        // Monitor is full scale at the internal limit
        monitorOut = 16'(scale(17'(torqueRef),
                               `SSL_MONITOR_FS_MV,
                               internalTorqueLimit));
    end

    // One process fills the carrier, so each field has a single driver
    always_comb begin
        next_drive.speedRefRpm = speedRef;
        next_drive.speedLimitRpm = speedLim;
        next_drive.torqueRefPct = torqueRef;
        next_drive.torqueLimitPct = activeLimit;
        next_drive.monitorMv = monitorOut;
    end

    // Zero speed window compare on the absolute speed
    always_comb begin
        if (motorSpeedRpm < 17'sh0_0000) begin
            next_zero = (17'(-motorSpeedRpm) <= {1'b0, zeroSpeedWindow});
        end else begin
            next_zero = (motorSpeedRpm <= $signed({1'b0, zeroSpeedWindow}));
        end
    end

    // Encoder output divider, at most one quadrature edge per step
    always_comb begin
        next_encAcc = encAcc;
        quadStep = 1'b0;
        if (encStep) begin
            unique case (encMode)
                SSL_ENC_PULSES: begin
                    // Setting edges spread over one revolution of counts
                    next_encAcc = encAcc + {1'b0, encoderOutputPulseSetting};
                    if (next_encAcc >= {1'b0, `SSL_ENC_RESOLUTION}) begin
                        next_encAcc = next_encAcc
                                      - {1'b0, `SSL_ENC_RESOLUTION};
                        quadStep = 1'b1;
                    end
                    // One edge per count at most: settings above the
                    // resolution drop the surplus rather than overflow
                    if (next_encAcc >= {1'b0, `SSL_ENC_RESOLUTION}) begin
                        next_encAcc = 17'h0_0000;
                    end
                end
                SSL_ENC_RATIO: begin
                    // One edge every setting counts
                    next_encAcc = encAcc + 17'h0_0001;
                    if (next_encAcc >= {1'b0, encoderOutputPulseSetting}) begin
                        next_encAcc = 17'h0_0000;
                        quadStep = 1'b1;
                    end
                end
            endcase
        end
    end

    // Events for the sticky status
    assign events[`SSL_ST_ZERO_BIT] = next_zero && !zeroSpeedFlag;
    assign events[`SSL_ST_TLIM_BIT] = (torqueRef != 16'(torqueRaw));
    assign events[`SSL_ST_OFS_BIT] = autoOffsetStart;

    // Setting registers, range clamps on all but the encoder setting, control and mask
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            zeroSpeedWindow <= `SSL_RST_ZERO_WIN;
            analogFullScaleSpeed <= `SSL_RST_FULL_SPEED;
            torqueCommandFullScale <= `SSL_RST_TORQUE_FS;
            encoderOutputPulseSetting <= `SSL_RST_ENC_SETTING;
            internalTorqueLimit <= `SSL_RST_INT_TLIM;
            control <= `SSL_RST_CONTROL;
            mask <= 3'(`SSL_RST_MASK);
        end else if (regWrite) begin
            unique case (regAddr)
                `SSL_IDX_ZERO_WIN: begin
                    zeroSpeedWindow <= clampU(regWdata, `SSL_MAX_ZERO_WIN);
                end
                `SSL_IDX_FULL_SPEED: begin
                    analogFullScaleSpeed <= clampU(regWdata,
                                                   `SSL_MAX_FULL_SPEED);
                end
                `SSL_IDX_TORQUE_FS: begin
                    torqueCommandFullScale <= clampU(regWdata,
                                                     `SSL_MAX_TORQUE_FS);
                end
                `SSL_IDX_ENC_SETTING: begin
                    encoderOutputPulseSetting <= regWdata;
                end
                `SSL_IDX_INT_TLIM: begin
                    internalTorqueLimit <= clampU(regWdata,
                                                  `SSL_MAX_INT_TLIM);
                end
                `SSL_IDX_CONTROL: begin
                    control <= regWdata & 16'h0003;
                end
                `SSL_IDX_MASK: begin
                    mask <= regWdata[2:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Offset setting, written by software or by the automatic function
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            speedInputOffset <= `SSL_RST_SPEED_OFS;
        end else if (autoOffsetStart) begin
            // Offset that brings the present input back to zero
            speedInputOffset <= clampOfs(-17'(analogIn.speedCmdMv));
        end else if (regWrite && regAddr == `SSL_IDX_SPEED_OFS) begin
            speedInputOffset <= clampOfs(17'($signed(regWdata)));
        end
    end

    // Sticky status: a read clears, a new event in that cycle wins
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            status <= 3'h0;
        end else if (statusRead) begin
            status <= events;
        end else begin
            status <= status | events;
        end
    end

    // Interrupt output from flops, one cycle behind the status
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // Registered results
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            driveOut <= '0;
            zeroSpeedFlag <= 1'b0;
        end else begin
            driveOut <= next_drive;
            zeroSpeedFlag <= next_zero;
        end
    end

    // Quadrature generator, Gray sequence keeps one pin moving at a time
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            encAcc <= 17'h0_0000;
            quadPhase <= 2'h0;
        end else begin
            encAcc <= next_encAcc;
            if (quadStep) begin
                // Four edges make one A/B cycle
                quadPhase <= encReverse ? quadPhase - 2'h1
                                        : quadPhase + 2'h1;
            end
        end
    end

    // Pins from flops; the rate limit is left to the user's setting
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            encOutA <= 1'b0;
            encOutB <= 1'b0;
        end else begin
            encOutA <= quadPhase[1];
            encOutB <= quadPhase[1] ^ quadPhase[0];
        end
    end

    // Read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            unique case (regAddr)
                `SSL_IDX_ZERO_WIN: regRdata <= zeroSpeedWindow;
                `SSL_IDX_FULL_SPEED: regRdata <= analogFullScaleSpeed;
                `SSL_IDX_TORQUE_FS: regRdata <= torqueCommandFullScale;
                `SSL_IDX_ENC_SETTING: regRdata <= encoderOutputPulseSetting;
                `SSL_IDX_INT_TLIM: regRdata <= internalTorqueLimit;
                `SSL_IDX_SPEED_OFS: regRdata <= speedInputOffset;
                `SSL_IDX_CONTROL: regRdata <= control;
                `SSL_IDX_STATUS: regRdata <= {13'h0000, status};
                `SSL_IDX_MASK: regRdata <= {13'h0000, mask};
                default: regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end

endmodule

// ==== sim/ssl_host_model.sv ====
module ssl_host_model
    import ssl_pkg::*;
(
    // Clock
    input wire logic clock,
    // Commands to the amplifier
    output ssl_analog_s analogIn,
    output logic torqueLimitSelect,
    output logic autoOffsetStart,
    // Pulse feedback
    input wire logic encOutA,
    input wire logic encOutB
);
    timeunit 1ns;
    timeprecision 1ns;
    int edgeCnt = 0;
    logic lastA = 1'b0;
    logic lastB = 1'b0;

    initial begin
        analogIn = '0;
        torqueLimitSelect = 1'b0;
        autoOffsetStart = 1'b0;
    end

    // Counts every A and B edge; stays valid up to one edge per pin per clock
    always @(posedge clock) begin
        edgeCnt <= edgeCnt + int'(encOutA != lastA) + int'(encOutB != lastB);
        lastA <= encOutA;
        lastB <= encOutB;
    end

    // New levels land just after a rising edge
    task automatic drive(input ssl_analog_s a, input logic sel);
        @(posedge clock);
        analogIn <= a;
        torqueLimitSelect <= sel;
    endtask

    // One-cycle request for an offset capture
    task automatic pulse_offset();
        @(posedge clock);
        autoOffsetStart <= 1'b1;
        @(posedge clock);
        autoOffsetStart <= 1'b0;
    endtask
endmodule

// ==== sim/ssl_scaling_sva.sv ====
`include "ssl_map.svh"

module ssl_scaling_sva
    import ssl_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdata,
    // Inputs that shape the results
    input wire ssl_analog_s analogIn,
    input wire logic torqueLimitSelect,
    input wire logic signed [16:0] motorSpeedRpm,
    input wire logic encStep,
    // Results
    input wire ssl_drive_s driveOut,
    input wire logic zeroSpeedFlag,
    input wire logic encOutA,
    input wire logic encOutB,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] win;
    logic [15:0] lim;
    logic [15:0] msk;
    logic [15:0] anaPct;
    logic [15:0] expLim;
    logic [16:0] spdAbs;
    logic signed [16:0] limS;
    logic armed;

    // Shadows of the settings; armed skips the first edge after reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            win <= `SSL_RST_ZERO_WIN;
            lim <= `SSL_RST_INT_TLIM;
            msk <= `SSL_RST_MASK;
            armed <= 1'b0;
        end else begin
            armed <= 1'b1;
            if (regWr && regAddr == `SSL_IDX_ZERO_WIN)
                win <= (regWdata > 16'h2710) ? 16'h2710 : regWdata;
            if (regWr && regAddr == `SSL_IDX_INT_TLIM)
                lim <= (regWdata > 16'h0064) ? 16'h0064 : regWdata;
            if (regWr && regAddr == `SSL_IDX_MASK)
                msk <= regWdata;
        end
    end

    // Analog limit in percent, 10 V is full torque
    assign anaPct = (analogIn.torqueLimitMv <= 16'sh0000) ? 16'h0000
        : 16'(analogIn.torqueLimitMv / 100);
    assign expLim = (torqueLimitSelect && anaPct < lim) ? anaPct : lim;
    assign spdAbs = motorSpeedRpm[16] ? 17'(-motorSpeedRpm) : motorSpeedRpm;
    assign limS = $signed({1'b0, driveOut.torqueLimitPct});

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    sequence winRead;
        regRd && regAddr == `SSL_IDX_ZERO_WIN;
    endsequence

    sequence quadMove;
        $changed(encOutA) || $changed(encOutB);
    endsequence

    chk_zero_window: assert property (
        armed |-> zeroSpeedFlag == ($past(spdAbs) <= $past(win)))
        else $error("zero speed flag disagrees with window");
    chk_window_read: assert property (
        winRead |=> regRdata == $past(win))
        else $error("window read back wrong");
    chk_limit_select: assert property (
        armed |-> driveOut.torqueLimitPct == $past(expLim))
        else $error("applied torque limit wrong");
    chk_no_torque: assert property (
        armed && $past(lim) == 16'h0000 |-> driveOut.torqueRefPct == 16'h0000)
        else $error("torque produced with zero limit");
    chk_torque_bound: assert property (
        armed |-> driveOut.torqueRefPct <= limS
            && driveOut.torqueRefPct >= -limS)
        else $error("torque above applied limit");
    chk_zero_torque: assert property (
        armed && $past(analogIn.torqueCmdMv) == 16'h0000
            |-> driveOut.torqueRefPct == 16'h0000)
        else $error("torque without command");
    chk_quad_launch: assert property (
        quadMove |-> $past(encStep, 2))
        else $error("quadrature moved without a step");
    chk_quad_gray: assert property (
        quadMove |-> !($changed(encOutA) && $changed(encOutB)))
        else $error("both quadrature pins moved");
    chk_irq_masked: assert property (
        irq |-> $past(msk) != 16'h0000)
        else $error("interrupt with all sources masked");
endmodule

bind ssl_servo_scaling ssl_scaling_sva chk_u (
    .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .analogIn(analogIn), .torqueLimitSelect(torqueLimitSelect),
    .motorSpeedRpm(motorSpeedRpm), .encStep(encStep), .driveOut(driveOut),
    .zeroSpeedFlag(zeroSpeedFlag), .encOutA(encOutA), .encOutB(encOutB),
    .irq(irq)
);

// ==== sim/ssl_servo_scaling_tb_top.sv ====
`include "ssl_map.svh"

module ssl_servo_scaling_tb_top import ssl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata;
    ssl_analog_s analogIn;
    logic torqueLimitSelect, autoOffsetStart;
    logic signed [16:0] motorSpeedRpm = 17'h0_0000;
    logic [15:0] ratedSpeedRpm = 16'h0BB8;
    logic encStep = 1'b0;
    logic encReverse = 1'b0;
    ssl_drive_s driveOut;
    logic zeroSpeedFlag, encOutA, encOutB, irq;
    int errorCnt = 0;
    int nChecks = 0;
    int cmd, seed;
    ssl_analog_s anaVal = '0;
    int rstTab [9] = '{50, 0, 100, 4000, 100, 0, 0, 0, 0};
    int spdTab [5] = '{50, 51, -50, -51, 0};
    // Index, written value, value read back after clamping
    int clampTab [6][3] = '{'{0, 65535, 10000}, '{1, 65535, 50000},
        '{2, 65535, 1000}, '{4, 65535, 100}, '{5, 1024, 999},
        '{5, 64512, 64537}};
    // Scale, limit, select, command, analog limit, torque, limit, monitor
    int tqTab [6][8] = '{'{50, 100, 0, 8000, 0, 50, 100, 4000},
        '{50, 100, 0, -8000, 0, -50, 100, -4000},
        '{50, 30, 0, 8000, 0, 30, 30, 8000},
        '{50, 30, 1, 8000, 2000, 20, 20, 5333},
        '{50, 30, 1, 8000, 9000, 30, 30, 8000},
        '{200, 0, 0, 4000, 0, 0, 0, 0}};

    ssl_servo_scaling dut_u (.clock(clock), .rstn(rstn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .analogIn(analogIn),
        .torqueLimitSelect(torqueLimitSelect),
        .autoOffsetStart(autoOffsetStart), .motorSpeedRpm(motorSpeedRpm),
        .ratedSpeedRpm(ratedSpeedRpm), .encStep(encStep),
        .encReverse(encReverse), .driveOut(driveOut),
        .zeroSpeedFlag(zeroSpeedFlag), .encOutA(encOutA),
        .encOutB(encOutB), .irq(irq));
    ssl_host_model host_u (.clock(clock), .analogIn(analogIn),
        .torqueLimitSelect(torqueLimitSelect),
        .autoOffsetStart(autoOffsetStart), .encOutA(encOutA),
        .encOutB(encOutB));

    initial begin
        forever #50 clock = ~clock;
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errorCnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(int a, int d);
        @(posedge clock);
        regAddr <= 4'(a);
        regWdata <= 16'(d);
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(int a, int e, string what, int m = 65535);
        @(posedge clock);
        regAddr <= 4'(a);
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        @(negedge clock);
        check(what, regRdata & 16'(m), e);
    endtask

    task automatic settle();
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic do_reset();
        @(posedge clock);
        rstn <= 1'b0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
    endtask

    // One step every four cycles keeps edges at 2.5 Mpps or less
    task automatic steps(int n, int exp);
        int start;
        start = host_u.edgeCnt;
        repeat (n) begin
            @(posedge clock);
            encStep <= 1'b1;
            encReverse <= 1'($urandom);
            @(posedge clock);
            encStep <= 1'b0;
            repeat (2) @(posedge clock);
        end
        repeat (3) @(posedge clock);
        check("edge count", host_u.edgeCnt - start, exp);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        errorCnt++;
        wrap_up();
    end

    initial begin
        seed = $urandom(32'h6110_cf61);
        do_reset();
        for (int i = 0; i < 9; i++)
            if (i != 7) rd(i, rstTab[i], "reset value");
        wr(15, 4660);
        rd(15, 0, "unmapped");
        // Zero speed edges of the default window
        foreach (spdTab[i]) begin
            @(posedge clock);
            motorSpeedRpm <= 17'(spdTab[i]);
            settle();
            check("zero flag", zeroSpeedFlag, spdTab[i] inside {[-50:50]});
        end
        // Random speed commands with the two extremes first
        wr(`SSL_IDX_FULL_SPEED, 1000);
        for (int i = 0; i < 24; i++) begin
            cmd = (i < 2) ? 10000 - 20000 * i : $urandom_range(20000) - 10000;
            anaVal.speedCmdMv = 16'(cmd);
            host_u.drive(anaVal, 1'b0);
            settle();
            check("speed ref", driveOut.speedRefRpm, cmd / 10);
            check("speed limit", driveOut.speedLimitRpm, 1000);
        end
        wr(`SSL_IDX_FULL_SPEED, 0);
        settle();
        check("rated speed", driveOut.speedRefRpm, cmd * 3000 / 10000);
        wr(`SSL_IDX_SPEED_OFS, 500);
        wr(`SSL_IDX_CONTROL, 2);
        anaVal.speedLimitMv = 16'h1388;
        host_u.drive(anaVal, 1'b0);
        settle();
        check("offset", driveOut.speedRefRpm, (cmd + 500) * 3 / 10);
        check("limit", driveOut.speedLimitRpm, 1650);
        foreach (tqTab[i]) begin
            wr(`SSL_IDX_TORQUE_FS, tqTab[i][0]);
            wr(`SSL_IDX_INT_TLIM, tqTab[i][1]);
            anaVal.torqueCmdMv = 16'(tqTab[i][3]);
            anaVal.torqueLimitMv = 16'(tqTab[i][4]);
            host_u.drive(anaVal, tqTab[i][2][0]);
            settle();
            check("torque", driveOut.torqueRefPct, tqTab[i][5]);
            check("torque limit", driveOut.torqueLimitPct, tqTab[i][6]);
            check("monitor", driveOut.monitorMv, tqTab[i][7]);
        end
        // Offset capture raises an unmasked event, a status read clears it
        wr(`SSL_IDX_MASK, 4);
        anaVal.speedCmdMv = 16'hFED4;
        host_u.drive(anaVal, 1'b0);
        host_u.pulse_offset();
        settle();
        rd(`SSL_IDX_SPEED_OFS, 300, "auto offset");
        check("irq set", irq, 1);
        rd(`SSL_IDX_STATUS, 4, "status", 4);
        rd(`SSL_IDX_STATUS, 0, "status clear", 4);
        check("irq clear", irq, 0);
        wr(`SSL_IDX_MASK, 0);
        host_u.pulse_offset();
        settle();
        check("irq masked", irq, 0);
        foreach (clampTab[i]) begin
            wr(clampTab[i][0], clampTab[i][1]);
            rd(clampTab[i][0], clampTab[i][2], "clamp");
        end
        do_reset();
        steps(1000, 400);
        do_reset();
        wr(`SSL_IDX_CONTROL, 1);
        wr(`SSL_IDX_ENC_SETTING, 8);
        steps(80, 10);
        wrap_up();
    end
endmodule
